// ---- sev_top.sv ----
`timescale 1ns/1ps
`include "sev_cfg.svh"

module sev_top (
  input  wire logic            ref_clk_i,   // System clock
  input  wire logic            rst_i,       // Sync reset, active high
  input  wire logic            psel_i,      // APB select
  input  wire logic            penable_i,   // APB enable
  input  wire logic            pwrite_i,    // APB write
  input  wire logic [7:0]      paddr_i,     // APB byte address
  input  wire logic [31:0]     pwdata_i,    // APB write data
  output logic      [31:0]     prdata_o,    // APB read data
  output logic                 pready_o,    // APB ready
  output logic                 pslverr_o,   // APB error, unmapped
  input  wire sev_pkg::sev_vec_t qevt_i,    // Quick channel event pulses
  input  wire sev_pkg::sev_vec_t qnull_i,   // Channel request is null/dummy
  input  wire sev_pkg::sev_vec_t nq_set_i,  // Normal channel queued pulses
  output logic                 tr_valid_o,  // Request offered
  output sev_pkg::sev_chan_t   tr_chan_o,   // Offered channel
  output logic                 tr_null_o,   // Offered request is null/dummy
  input  wire logic            tr_ready_i   // Transfer side takes request
);
  import sev_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  sev_state_t state;
  sev_state_t next_state;
  sev_vec_t   en_bits;
  sev_vec_t   nq_stat;
  sev_vec_t   evt;
  sev_vec_t   queued;
  sev_vec_t   elig;
  sev_vec_t   enq;
  sev_vec_t   done;
  sev_vec_t   qclr;
  sev_vec_t   next_nq;
  sev_chan_t  pick;
  logic       any_elig;
  logic       launch;
  logic       acc;
  logic       wr;
  logic       mapped;
  logic       nclr_wr;
  logic [31:0] rd_mux;
  logic       next_valid;
  sev_chan_t  next_chan;
  logic       next_null;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  assign launch  = psel_i & penable_i & ~pready_o;
  assign acc     = psel_i & penable_i & pready_o;
  assign wr      = acc & pwrite_i;
  assign mapped  = (paddr_i == `SEV_OFF_EVT)   | (paddr_i == `SEV_OFF_EN)
                 | (paddr_i == `SEV_OFF_QSTAT) | (paddr_i == `SEV_OFF_QCLR)
                 | (paddr_i == `SEV_OFF_NSTAT) | (paddr_i == `SEV_OFF_NCLR);
  assign qclr    = (wr && paddr_i == `SEV_OFF_QCLR)
                 ? pwdata_i[`SEV_NCH-1:0] : `SEV_RST_CH;
  assign nclr_wr = wr && (paddr_i == `SEV_OFF_NCLR);

  // Read mux, write-only registers read as zero
  assign rd_mux =
      (paddr_i == `SEV_OFF_EVT)   ? {`SEV_PAD, evt}     :
      (paddr_i == `SEV_OFF_EN)    ? {`SEV_PAD, en_bits} :
      (paddr_i == `SEV_OFF_QSTAT) ? {`SEV_PAD, queued}  :
      (paddr_i == `SEV_OFF_NSTAT) ? {`SEV_PAD, nq_stat} :
      `SEV_RST_DATA;

  // Normal channel queued bits: set wins, clear leaves events alone
  assign next_nq = nq_set_i
                 | (nq_stat & ~(nclr_wr ? pwdata_i[`SEV_NCH-1:0]
                                        : `SEV_RST_CH));

  ////////////////////////////////////////////////////////////////////////
  // APB response and software registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= `SEV_RST_DATA;
      en_bits   <= `SEV_RST_CH;
      nq_stat   <= `SEV_RST_CH;
    end else begin
      pready_o  <= launch;
      pslverr_o <= launch & ~mapped;
      prdata_o  <= (launch & ~pwrite_i) ? rd_mux : `SEV_RST_DATA;
      nq_stat   <= next_nq;
      if (wr && paddr_i == `SEV_OFF_EN) begin
        en_bits <= pwdata_i[`SEV_NCH-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel trackers
  genvar g;
  generate
    for (g = 0; g < `SEV_NCH; g++) begin : g_ch
      sev_chan u_chan (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .evt_i     (qevt_i[g]),
        .en_i      (en_bits[g]),
        .enq_i     (enq[g]),
        .done_i    (done[g]),
        .null_i    (tr_null_o),
        .clr_i     (qclr[g]),
        .evt_o     (evt[g]),
        .queued_o  (queued[g]),
        .elig_o    (elig[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Lowest eligible channel wins
  always_comb begin
    pick = `SEV_RST_CHAN;
    for (int i = `SEV_NCH - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick = sev_chan_t'(i);
      end
    end
  end

  assign any_elig = |elig;
  assign enq  = (state == SEV_IDLE && any_elig)
              ? sev_vec_t'(1 << pick) : `SEV_RST_CH;
  assign done = (state == SEV_OFFER && tr_ready_i)
              ? sev_vec_t'(1 << tr_chan_o) : `SEV_RST_CH;

  // Offer sequencer next state
  always_comb begin
    next_state = state;
    next_valid = tr_valid_o;
    next_chan  = tr_chan_o;
    next_null  = tr_null_o;
    case (state)
      SEV_IDLE: begin
        if (any_elig) begin
          next_state = SEV_OFFER;
          next_valid = 1'b1;
          next_chan  = pick;
          next_null  = qnull_i[pick];
        end
      end
      SEV_OFFER: begin
        if (tr_ready_i) begin
          next_state = SEV_IDLE;
          next_valid = 1'b0;
        end
      end
      default: begin
        next_state = SEV_IDLE;
        next_valid = 1'b0;
      end
    endcase
  end

  // Offer sequencer flops
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state      <= SEV_IDLE;
      tr_valid_o <= 1'b0;
      tr_chan_o  <= `SEV_RST_CHAN;
      tr_null_o  <= 1'b0;
    end else begin
      state      <= next_state;
      tr_valid_o <= next_valid;
      tr_chan_o  <= next_chan;
      tr_null_o  <= next_null;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sev_vec_t queued_d;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      queued_d <= `SEV_RST_CH;
    end else begin
      queued_d <= queued;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_fresh_offer;
    $rose(tr_valid_o) |-> !queued_d[tr_chan_o] && queued[tr_chan_o];
  endproperty
  a_fresh_offer: assert property (p_fresh_offer)
    else $error("offer made for a channel already queued");

  property p_nclr_only;
    nclr_wr && nq_set_i == `SEV_RST_CH && !(|(qevt_i & en_bits))
      && !(|done)
      |=> ((nq_stat & $past(pwdata_i[`SEV_NCH-1:0])) == `SEV_RST_CH)
      && (evt == $past(evt));
  endproperty
  a_nclr_only: assert property (p_nclr_only)
    else $error("normal clear wrong or touched event bits");

  property p_stat_read;
    launch && !pwrite_i && paddr_i == `SEV_OFF_QSTAT
      |=> pready_o && prdata_o == {`SEV_PAD, $past(queued)};
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status read data wrong");

  property p_clr_read;
    launch && !pwrite_i && paddr_i == `SEV_OFF_QCLR
      |=> pready_o && !pslverr_o && prdata_o == `SEV_RST_DATA;
  endproperty
  a_clr_read: assert property (p_clr_read)
    else $error("clear register did not read zero");

  c_offer:   cover property ($rose(tr_valid_o) ##[1:10] tr_ready_i);
  c_qclr:    cover property (|qclr && |queued);
  c_blocked: cover property (|(queued & evt) && tr_valid_o);
endmodule

// ---- sev_cfg.svh ----
`ifndef SEV_CFG_SVH
`define SEV_CFG_SVH

// Channel geometry
`define SEV_NCH        4
`define SEV_CHW        2
`define SEV_AW         8
`define SEV_DW         32

// Register byte addresses
`define SEV_OFF_EVT    8'h00
`define SEV_OFF_EN     8'h04
`define SEV_OFF_QSTAT  8'h08
`define SEV_OFF_QCLR   8'h0C
`define SEV_OFF_NSTAT  8'h10
`define SEV_OFF_NCLR   8'h14

// Reset values
`define SEV_RST_CH     4'h0
`define SEV_RST_DATA   32'h0000_0000
`define SEV_RST_CHAN   2'h0
`define SEV_PAD        28'h000_0000

`endif

// ---- sev_pkg.sv ----
`include "sev_cfg.svh"

package sev_pkg;
  // Offer sequencer states, one-hot
  typedef enum logic [1:0] {
    SEV_IDLE  = 2'h1,
    SEV_OFFER = 2'h2
  } sev_state_t;

  typedef logic [`SEV_CHW-1:0] sev_chan_t;
  typedef logic [`SEV_NCH-1:0] sev_vec_t;
endpackage

// ---- sev_chan.sv ----
`timescale 1ns/1ps
`include "sev_cfg.svh"

module sev_chan (
  input  wire logic ref_clk_i,  // System clock
  input  wire logic rst_i,      // Sync reset, active high
  input  wire logic evt_i,      // Incoming event pulse
  input  wire logic en_i,       // Channel enable bit
  input  wire logic enq_i,      // Channel entered the queue
  input  wire logic done_i,     // Request handed to transfer side
  input  wire logic null_i,     // Handed request was null or dummy
  input  wire logic clr_i,      // Software queued-clear strobe
  output logic      evt_o,      // Event bit
  output logic      queued_o,   // Queued-status bit
  output logic      elig_o      // May enter prioritisation
);
  logic next_evt;
  logic next_queued;

  // Event latch: enable gates capture, a new event beats any clear
  assign next_evt    = (evt_i & en_i)
                     | (evt_o & ~done_i & ~clr_i);
  // Queued bit: set on enqueue, auto-clear only for valid requests
  assign next_queued = enq_i
                     | (queued_o & ~clr_i
                        & ~(done_i & ~null_i));
  // A queued channel is kept out of prioritisation
  assign elig_o      = evt_o & ~queued_o;

  // State flops
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      evt_o    <= 1'b0;
      queued_o <= 1'b0;
    end else begin
      evt_o    <= next_evt;
      queued_o <= next_queued;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_enq_sets;
    enq_i |=> queued_o ##1 (queued_o || $past(clr_i) || $past(done_i));
  endproperty
  a_enq_sets: assert property (p_enq_sets)
    else $error("enqueue did not set queued bit");

  property p_block;
    queued_o |-> !elig_o && !enq_i;
  endproperty
  a_block: assert property (p_block)
    else $error("queued channel still eligible");

  property p_clr_both;
    clr_i && !enq_i && !(evt_i && en_i) |=> !queued_o && !evt_o;
  endproperty
  a_clr_both: assert property (p_clr_both)
    else $error("clear write left a bit set");

  property p_hold;
    queued_o && !clr_i && !(done_i && !null_i) |=> queued_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("queued bit dropped without cause");

  property p_evt_hold;
    evt_o && !done_i && !clr_i |=> evt_o;
  endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("event bit dropped before hand-over");

  property p_disabled;
    !en_i && !evt_o |=> !evt_o;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("event latched on disabled channel");

  property p_auto;
    done_i && queued_o && !clr_i |=> (queued_o == $past(null_i));
  endproperty
  a_auto: assert property (p_auto)
    else $error("queued bit wrong after hand-over");

  c_null_wait: cover property (done_i && null_i ##1 queued_o ##[1:20] clr_i);
endmodule

// ---- sev_xfer_model.sv ----
`timescale 1ns/1ps
module sev_xfer_model (
  input  wire logic          ref_clk_i, // System clock
  input  wire logic          rst_i,     // Sync reset
  input  wire logic          valid_i,   // Offer present
  input  wire sev_pkg::sev_chan_t chan_i, // Offered channel
  input  wire logic          null_i,    // Offer is null
  input  wire logic [3:0]    lat_i,     // Stall cycles
  output logic               ready_o,   // Accept
  output sev_pkg::sev_chan_t chan_o,    // Last taken channel
  output logic               null_o,    // Last taken null flag
  output logic [7:0]         cnt_o      // Offers taken
);
  import sev_pkg::*;
  logic [3:0] wait_q;
  // Takes one offer after a chosen stall
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      wait_q  <= 4'h0;
      chan_o  <= 2'h0;
      null_o  <= 1'b0;
      cnt_o   <= 8'h00;
    end else if (valid_i && ready_o) begin
      ready_o <= 1'b0;
      wait_q  <= 4'h0;
      chan_o  <= chan_i;
      null_o  <= null_i;
      cnt_o   <= cnt_o + 8'h01;
    end else if (valid_i && wait_q >= lat_i) begin
      ready_o <= 1'b1;
    end else if (valid_i) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "sev_cfg.svh"
module tb_top;
  import sev_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  sev_vec_t    qevt_i    = 4'h0;
  sev_vec_t    qnull_i   = 4'h0;
  sev_vec_t    nq_set_i  = 4'h0;
  logic        tr_valid_o;
  sev_chan_t   tr_chan_o;
  logic        tr_null_o;
  logic        tr_ready_i;
  logic [3:0]  lat       = 4'h0;
  sev_chan_t   got_chan;
  logic        got_null;
  logic [7:0]  n_taken;
  int          fails     = 0;
  int          n_compared = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  sev_top sev_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .qevt_i(qevt_i),
    .qnull_i(qnull_i), .nq_set_i(nq_set_i), .tr_valid_o(tr_valid_o),
    .tr_chan_o(tr_chan_o), .tr_null_o(tr_null_o),
    .tr_ready_i(tr_ready_i));
  sev_xfer_model sev_xfer_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .valid_i(tr_valid_o), .chan_i(tr_chan_o), .null_i(tr_null_o),
    .lat_i(lat), .ready_o(tr_ready_i), .chan_o(got_chan),
    .null_o(got_null), .cnt_o(n_taken));

  ////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int i;
    @(posedge ref_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (pready_o === 1'b1) break;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (i == 20) begin
      fails++;
      finish_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic experr = 1'b0);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, wd, d, e);
    chk({31'h0, e}, 32'h0);
  endtask

  // Event pulse with null flags and model stall
  task automatic pulse(input sev_vec_t v, input sev_vec_t n,
                       input logic [3:0] l);
    @(posedge ref_clk_i);
    qevt_i  <= v;
    qnull_i <= n;
    lat     <= l;
    @(posedge ref_clk_i);
    qevt_i <= 4'h0;
  endtask

  task automatic wait_taken(input logic [7:0] n);
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk_i);
      if (n_taken === n) break;
    end
    if (i == 50) begin
      fails++;
      finish_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(`SEV_OFF_QSTAT, 32'h0);
    rd(`SEV_OFF_QCLR, 32'h0);
    wr(`SEV_OFF_QSTAT, 32'hFFFF_FFFF);
    rd(`SEV_OFF_QSTAT, 32'h0);
    rd(8'h18, 32'h0, 1'b1);
    wr(`SEV_OFF_EN, 32'hFFFF_FFF0);
    rd(`SEV_OFF_EN, 32'h0);
    pulse(4'hF, 4'h0, 4'h0);
    rd(`SEV_OFF_EVT, 32'h0);
    chk({24'h0, n_taken}, 32'h0);
  endtask

  task automatic t_valid();
    wr(`SEV_OFF_EN, 32'hF);
    pulse(4'h2, 4'h0, 4'hA);
    rd(`SEV_OFF_EVT, 32'h2);
    rd(`SEV_OFF_QSTAT, 32'h2);
    wait_taken(8'h01);
    chk({31'h0, got_null}, 32'h0);
    chk({30'h0, got_chan}, 32'h1);
    rd(`SEV_OFF_EVT, 32'h0);
    rd(`SEV_OFF_QSTAT, 32'h0);
  endtask

  task automatic t_null();
    pulse(4'h4, 4'h4, 4'h0);
    wait_taken(8'h02);
    chk({31'h0, got_null}, 32'h1);
    rd(`SEV_OFF_QSTAT, 32'h4);
    pulse(4'h4, 4'h4, 4'h0);
    rd(`SEV_OFF_EVT, 32'h4);
    chk({24'h0, n_taken}, 32'h2);
    @(posedge ref_clk_i);
    nq_set_i <= 4'h5;
    @(posedge ref_clk_i);
    nq_set_i <= 4'h0;
    rd(`SEV_OFF_NSTAT, 32'h5);
    wr(`SEV_OFF_NCLR, 32'hF);
    rd(`SEV_OFF_NSTAT, 32'h0);
    rd(`SEV_OFF_EVT, 32'h4);
    wr(`SEV_OFF_QCLR, 32'h0);
    rd(`SEV_OFF_QSTAT, 32'h4);
    rd(`SEV_OFF_EVT, 32'h4);
    wr(`SEV_OFF_QCLR, 32'h4);
    rd(`SEV_OFF_QSTAT, 32'h0);
    rd(`SEV_OFF_EVT, 32'h0);
    pulse(4'h4, 4'h0, 4'h0);
    wait_taken(8'h03);
    chk({30'h0, got_chan}, 32'h2);
  endtask

  task automatic t_prio();
    pulse(4'h9, 4'h0, 4'h0);
    wait_taken(8'h04);
    chk({30'h0, got_chan}, 32'h0);
    wait_taken(8'h05);
    chk({30'h0, got_chan}, 32'h3);
    rd(`SEV_OFF_QSTAT, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_valid();
    t_null();
    t_prio();
    finish_test();
  end
endmodule
